/* File: rdcgs_pkg.sv */
// What this block does
// - Register accepts byte, halfword and word accesses through byte selects.
// - Reset value of the register is 0x00011B01.
// - Reserved bits read zero; software writes only zero into them.
// - Bit 28 low enters recovery after short self-test; high skips it.
// - Bit 24 low enables the recovery state function; high disables it.
// - Bits 23:20 set initial gain on recovery entry after self-test.
// - Initial gain code decodes 0000 x4, 0001 x1/16 up to 1000 x8.
// - Bit 16 high suppresses gain return to high after error or reset.
// - Bits 15:12 set the upper gain limit for 12/7-level schemes.
// - Bits 11:8 set the lower gain limit for 12/7-level schemes.
package rdcgs_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RDCGS_CTRL_GAIN_SEL_ONE_OFS = 8'h08;
  localparam logic [7:0] RDCGS_STATUS_OFS = 8'h0C;
  localparam logic [31:0] RDCGS_CTRL_RESET = 32'h00011B01;
  localparam logic [31:0] RDCGS_CTRL_WMASK = 32'h11F1FF07;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RDCGS_SELFTEST_DIS_BIT = 28;
  localparam int RDCGS_RECOVERY_DIS_BIT = 24;
  localparam int RDCGS_INIT_GAIN_LSB = 20;
  localparam int RDCGS_RAISE_RESTRICT_BIT = 16;
  localparam int RDCGS_UPPER_LIMIT_LSB = 12;
  localparam int RDCGS_LOWER_LIMIT_LSB = 8;
  localparam int RDCGS_LOWEST_LSB = 0;
  // ----------------------------------------
  // Gain encoding: log2 of gain plus 4 (x0.0625 is 0, x128 is 11)
  // ----------------------------------------
  localparam logic [3:0] RDCGS_GAIN_X4 = 4'h6;
  localparam logic [3:0] RDCGS_GAIN_X128 = 4'hB;
  localparam logic [3:0] RDCGS_GAIN_X16 = 4'h8;
endpackage

/* File: rdcgs_gain_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module rdcgs_gain_decode #(
  parameter logic [3:0] HI_CODE_9 = rdcgs_pkg::RDCGS_GAIN_X16,
  parameter logic [3:0] HI_CODE_A = rdcgs_pkg::RDCGS_GAIN_X128,
  parameter logic [3:0] HI_CODE_B = rdcgs_pkg::RDCGS_GAIN_X4,
  parameter logic [3:0] HI_CODE_C = rdcgs_pkg::RDCGS_GAIN_X4,
  parameter logic [3:0] HI_CODE_D = rdcgs_pkg::RDCGS_GAIN_X4,
  parameter logic [3:0] HI_CODE_E = rdcgs_pkg::RDCGS_GAIN_X4,
  parameter logic [3:0] HI_CODE_F = rdcgs_pkg::RDCGS_GAIN_X4
) (
  // Code in, log2 gain out
  input wire logic [3:0] code_i,
  output logic [3:0] gain_o
);
  always_comb begin
    case (code_i)
      4'h0: gain_o = rdcgs_pkg::RDCGS_GAIN_X4;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: gain_o = 4'(code_i - 4'h1);
      // Upper codes unconfirmed, kept adjustable
      4'h9: gain_o = HI_CODE_9;
      4'hA: gain_o = HI_CODE_A;
      4'hB: gain_o = HI_CODE_B;
      4'hC: gain_o = HI_CODE_C;
      4'hD: gain_o = HI_CODE_D;
      4'hE: gain_o = HI_CODE_E;
      4'hF: gain_o = HI_CODE_F;
      default: gain_o = rdcgs_pkg::RDCGS_GAIN_X4;
    endcase
  end
endmodule
`default_nettype wire

/* File: rdcgs_reg.sv */
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module rdcgs_reg (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Loop events
  input wire logic selftest_done_i,
  input wire logic signal_error_recovered_i,
  input wire logic integrator_reset_i,
  // Loop controls
  output logic gain_recovery_state_o,
  output logic [3:0] initial_gain_o,
  output logic gain_raise_req_o,
  output logic [3:0] upper_gain_limit_o,
  output logic [3:0] lower_gain_limit_o,
  output logic [2:0] lowest_setting_field_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [3:0] decoded_gain;
  logic hit_ctrl;
  logic hit_status;
  logic req;
  logic selftest_recovery_gainrec_disable;
  logic gain_recovery_disable;
  logic gain_raise_restrict;

  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_ctrl = adr_i == rdcgs_pkg::RDCGS_CTRL_GAIN_SEL_ONE_OFS;
  assign hit_status = adr_i == rdcgs_pkg::RDCGS_STATUS_OFS;
  assign selftest_recovery_gainrec_disable = ctrl[rdcgs_pkg::RDCGS_SELFTEST_DIS_BIT];
  assign gain_recovery_disable = ctrl[rdcgs_pkg::RDCGS_RECOVERY_DIS_BIT];
  assign gain_raise_restrict = ctrl[rdcgs_pkg::RDCGS_RAISE_RESTRICT_BIT];

  // ----------------------------------------
  // Byte-lane write, reserved bits forced low
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    for (int i = 0; i < 4; i++) begin
      if (sel_i[i]) begin
        next_ctrl[i*8 +: 8] = dat_i[i*8 +: 8];
      end
    end
    next_ctrl = next_ctrl & rdcgs_pkg::RDCGS_CTRL_WMASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= rdcgs_pkg::RDCGS_CTRL_RESET;
    end else if (ce_i && req && we_i && hit_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------
  // Bus answer: one wait-free cycle, then ack, or err for an unmapped address
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= req & (hit_ctrl | hit_status);
      err_o <= req & ~(hit_ctrl | hit_status);
      if (req && !we_i && hit_ctrl) begin
        dat_o <= ctrl;
      end else if (req && !we_i && hit_status) begin
        dat_o <= {27'h0000000, gain_raise_req_o, decoded_gain};
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  rdcgs_gain_decode u_decode (
    .code_i(ctrl[rdcgs_pkg::RDCGS_INIT_GAIN_LSB +: 4]),
    .gain_o(decoded_gain)
  );

  // ----------------------------------------
  // Loop controls
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_recovery_state_o <= 1'b0;
      initial_gain_o <= rdcgs_pkg::RDCGS_GAIN_X4;
    end else if (ce_i) begin
      // Both the general and the self-test enable must allow entry
      if (selftest_done_i && !gain_recovery_disable && !selftest_recovery_gainrec_disable) begin
        gain_recovery_state_o <= 1'b1;
        initial_gain_o <= decoded_gain;
      end else begin
        gain_recovery_state_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_raise_req_o <= 1'b0;
    end else if (ce_i) begin
      gain_raise_req_o <= (signal_error_recovered_i | integrator_reset_i) & ~gain_raise_restrict;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_gain_limit_o <= rdcgs_pkg::RDCGS_CTRL_RESET[rdcgs_pkg::RDCGS_UPPER_LIMIT_LSB +: 4];
      lower_gain_limit_o <= rdcgs_pkg::RDCGS_CTRL_RESET[rdcgs_pkg::RDCGS_LOWER_LIMIT_LSB +: 4];
      lowest_setting_field_o <= rdcgs_pkg::RDCGS_CTRL_RESET[rdcgs_pkg::RDCGS_LOWEST_LSB +: 3];
    end else if (ce_i) begin
      upper_gain_limit_o <= ctrl[rdcgs_pkg::RDCGS_UPPER_LIMIT_LSB +: 4];
      lower_gain_limit_o <= ctrl[rdcgs_pkg::RDCGS_LOWER_LIMIT_LSB +: 4];
      lowest_setting_field_o <= ctrl[rdcgs_pkg::RDCGS_LOWEST_LSB +: 3];
    end
  end
endmodule
`default_nettype wire

/* File: rdcgs_reg_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module rdcgs_reg_sva (
  input wire logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, err_o,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i, initial_gain_o, upper_gain_limit_o, lower_gain_limit_o,
  input wire logic [31:0] dat_i, dat_o,
  input wire logic selftest_done_i, signal_error_recovered_i, integrator_reset_i,
  input wire logic gain_recovery_state_o, gain_raise_req_o
);
  // ----
  // Shadow, one cycle behind the register like the field outputs
  // ----
  localparam logic [31:0] WM = 32'h11F1FF07;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] sh;
  wire logic req = cyc_i && stb_i && ce_i && !ack_o && !err_o;
  wire logic ev = ce_i && (signal_error_recovered_i || integrator_reset_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) sh <= 32'h00011B01;
    else if (ce_i && cyc_i && stb_i && we_i && ack_o && adr_i == 8'h08)
      for (int i = 0; i < 4; i++) if (sel_i[i]) sh[8*i+:8] <= dat_i[8*i+:8] & WM[8*i+:8];
  end
  a_ack_mapped: assert property (req && adr_i == 8'h08 |=> ack_o && !err_o) else $error("no ack");
  a_err_unmapped: assert property (req && !(adr_i inside {8'h08, 8'h0C}) |=> err_o && !ack_o) else $error("no err");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
  a_read_data: assert property (ack_o && !we_i && adr_i == 8'h08 |-> dat_o == sh) else $error("bad read");
  a_limits_track: assert property (upper_gain_limit_o == sh[15:12] && lower_gain_limit_o == sh[11:8])
    else $error("limits");
  a_recov_entry: assert property (selftest_done_i && ce_i && !sh[28] && !sh[24] |=> gain_recovery_state_o)
    else $error("no entry");
  // Frozen state keeps its old pulse, so only enabled cycles count
  a_recov_skip: assert property (selftest_done_i && ce_i && (sh[28] || sh[24]) |=> !gain_recovery_state_o)
    else $error("entry");
  a_init_gain: assert property (gain_recovery_state_o && sh[23:20] <= 4'h8 |->
    initial_gain_o == (sh[23:20] == 4'h0 ? 4'h6 : sh[23:20] - 4'h1)) else $error("gain");
  a_raise_req: assert property (ev && !sh[16] |=> gain_raise_req_o) else $error("no raise");
  a_raise_hold: assert property (ev && sh[16] |=> !gain_raise_req_o) else $error("raise");
  c_entry: cover property (gain_recovery_state_o);
  c_raise: cover property (gain_raise_req_o);
  c_err: cover property (err_o);
endmodule
bind rdcgs_reg rdcgs_reg_sva u_rdcgs_reg_sva (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .ack_o, .err_o,
  .adr_i, .sel_i, .initial_gain_o, .upper_gain_limit_o, .lower_gain_limit_o, .dat_i, .dat_o, .selftest_done_i,
  .signal_error_recovered_i, .integrator_reset_i, .gain_recovery_state_o, .gain_raise_req_o);
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----
  // Hookup
  // ----
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, st = 0, er = 0, ir = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, ig, ul, ll;
  logic [31:0] dat_i = 32'h0, dat_o, rd, ex;
  logic ack_o, err_o, grs, grr, e;
  logic [2:0] lw;
  int fails = 0, n_tests = 0;
  // Expected log2 gain per code, code 0 in the low nibble
  localparam logic [63:0] GT = 64'h66666B8765432106;
  rdcgs_reg u_rdcgs_reg (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .err_o, .selftest_done_i(st), .signal_error_recovered_i(er), .integrator_reset_i(ir),
    .gain_recovery_state_o(grs), .initial_gain_o(ig), .gain_raise_req_o(grr), .upper_gain_limit_o(ul),
    .lower_gain_limit_o(ll), .lowest_setting_field_o(lw));
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while ((ack_o | err_o) !== 1'b1);
    rd = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Event fired only after the write has settled into the outputs
  task automatic fire(input logic [31:0] v, input logic [2:0] k);
    bus(1'b1, 8'h08, 4'hF, v);
    {st, er, ir} <= k;
    @(posedge clk_i);
    {st, er, ir} <= 3'b000;
    @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    $display("mismatch at %0t: timeout", $time);
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h08, 4'hF, 32'h0);
    chk(rd, 32'h00011B01, "reset");
    chk(32'({ig, ul, ll, 1'b0, lw}), 32'h61B1, "reset fields");
    $display("test reset done");
    ex = 32'h00011B01;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h08, 4'h1 << i, 32'hFFFFFFFF);
      ex[8*i+:8] = 8'(32'h11F1FF07 >> 8*i);
      bus(1'b0, 8'h08, 4'hF, 32'h0);
      chk(rd, ex, "byte write");
    end
    bus(1'b1, 8'h08, 4'h3, 32'h0);
    ex[15:0] = 16'h0;
    // Status word takes no writes but still answers with ack
    bus(1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF);
    chk(32'(e), 32'h0, "status write");
    bus(1'b1, 8'h04, 4'hF, 32'hFFFFFFFF);
    chk(32'(e), 32'h1, "unmapped");
    bus(1'b0, 8'h08, 4'hF, 32'h0);
    chk(rd, ex, "half write");
    chk(32'({ul, ll, 1'b0, lw}), 32'h0, "fields");
    $display("test access done");
    for (int c = 0; c < 16; c++) begin
      fire(32'h00011B01 | (32'(c) << 20), 3'b100);
      chk(32'({grs, ig}), 32'({1'b1, GT[4*c+:4]}), "entry");
      bus(1'b0, 8'h0C, 4'hF, 32'h0);
      chk(rd, 32'(GT[4*c+:4]), "status");
      fire(32'h10011B01, 3'b100);
      chk(32'({grs, ig}), 32'({1'b0, GT[4*c+:4]}), "skip 28");
      fire(32'h01011B01, 3'b100);
      chk(32'(grs), 32'h0, "skip 24");
    end
    $display("test recovery done");
    for (int k = 1; k < 3; k++) begin
      fire(32'h00001B01, 3'(k));
      chk(32'(grr), 32'h1, "raise");
      fire(32'h00011B01, 3'(k));
      chk(32'(grr), 32'h0, "no raise");
    end
    $display("test raise done");
    // Entry is allowed here, so only the frozen enable can hold it off
    ce_i <= 1'b0;
    st <= 1'b1;
    @(posedge clk_i);
    st <= 1'b0;
    @(posedge clk_i);
    chk(32'(grs), 32'h0, "frozen");
    ce_i <= 1'b1;
    @(posedge clk_i);
    $display("test enable done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h08, 4'hF, 32'h0);
    chk(rd, 32'h00011B01, "rerun reset");
    chk(32'({ig, ul, ll, 1'b0, lw}), 32'h61B1, "rerun fields");
    $display("test rerun reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
